/* File: core/adcsq_pkg.sv */
// package for the converter sequencer: register map, fields, timing constants
// Behaviour
// - each 12-bit conversion takes exactly thirteen bit periods
// - clock select picks 2..64 oscillator periods; codes ending 11 pick RC clock
// - RC clock gives a 2.5 us bit period at 10 MHz, as a fixed 25-clock count off the oscillator
// - a pin driven as output converts its digital output level
// - port reads return zero on pins configured as analog inputs
// - conversion ignores channel select and pin direction bits
// - zero acquisition time delays start by one instruction cycle
// - acquisition code 010 samples four bit periods then converts
// - clearing go aborts; result pair keeps its previous value
// - after completion or abort wait two bit periods then sample
// - discharge the holding capacitor before each sample that follows a completed or aborted conversion
// - compare trigger in mode 1011 with converter enabled sets go
// - each special event trigger resets the period counter
// - trigger ignored when converter disabled, counter still reset
// - on completion load result, clear go, set done flag, resume sampling
// - acquisition codes give 0,2,4,6,8,12,16,20 bit periods
// - format bit 7 set is right justified, clear is left
package adcsq_pkg;
   localparam logic [3:0] ADCSQ_OFS_RES_HI = 4'h0;
   localparam logic [3:0] ADCSQ_OFS_RES_LO = 4'h4;
   localparam logic [3:0] ADCSQ_OFS_CTRL0 = 4'h8;
   localparam logic [3:0] ADCSQ_OFS_CTRL1 = 4'hc;
   localparam logic [5:0] ADCSQ_OFS_CTRL2 = 6'h10;
   localparam logic [5:0] ADCSQ_OFS_STAT = 6'h14;
   localparam logic [5:0] ADCSQ_OFS_PORT = 6'h18;
   localparam int ADCSQ_BIT_ON = 0;
   localparam int ADCSQ_BIT_GO = 1;
   localparam int ADCSQ_BIT_FMT = 7;
   localparam logic [7:0] ADCSQ_RST_REG = 8'h00;
   localparam logic [3:0] ADCSQ_TRIG_MODE = 4'hb;
   localparam int ADCSQ_CONV_TAD = 13;
   localparam int ADCSQ_WAIT_TAD = 2;
   localparam int ADCSQ_CLK_MHZ = 10;
   localparam int ADCSQ_RC_TAD_NS = 2500;
   localparam int ADCSQ_RC_DIV = (ADCSQ_RC_TAD_NS * ADCSQ_CLK_MHZ) / 1000;
   localparam int ADCSQ_TCY_CLKS = 4;
   typedef enum logic [2:0] {
      ADCSQ_IDLE = 3'b000,
      ADCSQ_DELAY = 3'b001,
      ADCSQ_ACQ = 3'b011,
      ADCSQ_CONV = 3'b010,
      ADCSQ_WAIT = 3'b110
   } adcsq_state_t;
   typedef struct packed {
      logic [3:0] chan;
      logic [11:0] data;
   } adcsq_sample_t;
endpackage

/* File: core/adcsq_top.sv */
// converter sequencer: wishbone registers, bit period timing, conversion sequence
//
// Our own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ns
module adcsq_top
   import adcsq_pkg::*;
#(
   parameter int PORT_W = 12
)
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [5:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [3:0] compare_mode_select,
   input wire logic special_trigger,
   input wire logic [11:0] analog_sample,
   input wire logic [PORT_W-1:0] port_pins,
   output logic counter_reset_ff,
   output logic holding_discharge_ff,
   output logic sampling_ff,
   output logic conversion_done_flag_ff,
   output logic [3:0] channel_sel_ff
);
   logic ack_ff;
   logic [7:0] res_hi_ff, res_lo_ff, ctrl0_ff, ctrl1_ff, ctrl2_ff;
   logic [PORT_W-1:0] pin_s1_ff, pin_s2_ff, pin_s3_ff, port_ff;
   logic [6:0] div_ff;
   logic tad_tick;
   logic [6:0] tad_len;
   logic [4:0] cnt_ff;
   logic [4:0] acq_len;
   adcsq_state_t state_ff;
   logic [31:0] rd_data;
   logic bus_wr, bus_go_set, trig_go;
   logic [11:0] conv_val;
   logic converter_enable;
   assign converter_enable = ctrl0_ff[ADCSQ_BIT_ON];
   assign bus_wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_ff & wb_sel_i[0];
   assign bus_go_set = bus_wr && wb_adr_i == {2'b00, ADCSQ_OFS_CTRL0} && wb_dat_i[ADCSQ_BIT_GO];
   // trigger only counts with the converter on
   assign trig_go = special_trigger && compare_mode_select == ADCSQ_TRIG_MODE && converter_enable;

   // bit period length from clock select; rc source is a fixed count off mclk
   always_comb
   begin
      case (ctrl2_ff[2:0])
         3'b000: tad_len = 7'd2;
         3'b100: tad_len = 7'd4;
         3'b001: tad_len = 7'd8;
         3'b101: tad_len = 7'd16;
         3'b010: tad_len = 7'd32;
         3'b110: tad_len = 7'd64;
         default: tad_len = 7'(ADCSQ_RC_DIV);
      endcase
   end

   // acquisition length in bit periods
   always_comb
   begin
      case (ctrl2_ff[5:3])
         3'b000: acq_len = 5'd0;
         3'b001: acq_len = 5'd2;
         3'b010: acq_len = 5'd4;
         3'b011: acq_len = 5'd6;
         3'b100: acq_len = 5'd8;
         3'b101: acq_len = 5'd12;
         3'b110: acq_len = 5'd16;
         default: acq_len = 5'd20;
      endcase
   end

   // bit period divider, held in idle and start delay and cleared on abort, so no period starts part done
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         div_ff <= 7'h00;
      else if (state_ff == ADCSQ_IDLE || state_ff == ADCSQ_DELAY || tad_tick)
         div_ff <= 7'h00;
      else if (state_ff == ADCSQ_CONV && !ctrl0_ff[ADCSQ_BIT_GO])
         div_ff <= 7'h00;
      else
         div_ff <= div_ff + 7'h01;
   end
   assign tad_tick = (div_ff == tad_len - 7'h01);

   // result alignment; analog value taken regardless of pin direction or channel bits
   assign conv_val = analog_sample;

   // sequencer state machine
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_ff <= ADCSQ_IDLE;
         cnt_ff <= 5'h00;
      end
      else if (!converter_enable)
      begin
         state_ff <= ADCSQ_IDLE;
         cnt_ff <= 5'h00;
      end
      else
      begin
         case (state_ff)
            ADCSQ_IDLE:
               if (ctrl0_ff[ADCSQ_BIT_GO])
               begin
                  state_ff <= (acq_len == 5'd0) ? ADCSQ_DELAY : ADCSQ_ACQ;
                  cnt_ff <= (acq_len == 5'd0) ? 5'(ADCSQ_TCY_CLKS - 1) : acq_len - 5'd1;
               end
            ADCSQ_DELAY:
               if (!ctrl0_ff[ADCSQ_BIT_GO])
                  state_ff <= ADCSQ_IDLE;
               else if (cnt_ff == 5'h00)
               begin
                  state_ff <= ADCSQ_CONV;
                  cnt_ff <= 5'(ADCSQ_CONV_TAD - 1);
               end
               else
                  cnt_ff <= cnt_ff - 5'h01; // counts mclk cycles for one instruction
            ADCSQ_ACQ:
               if (!ctrl0_ff[ADCSQ_BIT_GO])
                  state_ff <= ADCSQ_IDLE;
               else if (tad_tick)
               begin
                  if (cnt_ff == 5'h00)
                  begin
                     state_ff <= ADCSQ_CONV;
                     cnt_ff <= 5'(ADCSQ_CONV_TAD - 1);
                  end
                  else
                     cnt_ff <= cnt_ff - 5'h01;
               end
            ADCSQ_CONV:
               if (!ctrl0_ff[ADCSQ_BIT_GO])
               begin
                  state_ff <= ADCSQ_WAIT;
                  cnt_ff <= 5'(ADCSQ_WAIT_TAD - 1);
               end
               else if (tad_tick)
               begin
                  if (cnt_ff == 5'h00)
                  begin
                     state_ff <= ADCSQ_WAIT;
                     cnt_ff <= 5'(ADCSQ_WAIT_TAD - 1);
                  end
                  else
                     cnt_ff <= cnt_ff - 5'h01;
               end
            ADCSQ_WAIT:
               if (tad_tick)
               begin
                  if (cnt_ff == 5'h00)
                     state_ff <= ADCSQ_IDLE;
                  else
                     cnt_ff <= cnt_ff - 5'h01;
               end
            default:
               state_ff <= ADCSQ_IDLE;
         endcase
      end
   end

   logic conv_end;
   assign conv_end = state_ff == ADCSQ_CONV && tad_tick && cnt_ff == 5'h00 && ctrl0_ff[ADCSQ_BIT_GO];

   // analog front end controls: discharge in the wait phase precedes each sample that follows a completed or aborted conversion
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         holding_discharge_ff <= 1'b0;
         sampling_ff <= 1'b0;
         channel_sel_ff <= 4'h0;
      end
      else
      begin
         holding_discharge_ff <= converter_enable && state_ff == ADCSQ_WAIT;
         sampling_ff <= converter_enable && (state_ff == ADCSQ_IDLE || state_ff == ADCSQ_ACQ);
         channel_sel_ff <= ctrl0_ff[5:2];
      end
   end

   // trigger pulse to the period counter, independent of converter enable
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         counter_reset_ff <= 1'b0;
      else
         counter_reset_ff <= special_trigger && compare_mode_select == ADCSQ_TRIG_MODE;
   end

   // control registers; hardware go-clear on completion, trigger set wins over clear
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ctrl0_ff <= ADCSQ_RST_REG;
         ctrl1_ff <= ADCSQ_RST_REG;
         ctrl2_ff <= ADCSQ_RST_REG;
      end
      else
      begin
         if (bus_wr && wb_adr_i == {2'b00, ADCSQ_OFS_CTRL0})
            ctrl0_ff <= {2'b00, wb_dat_i[5:0]};
         else if (conv_end)
            ctrl0_ff[ADCSQ_BIT_GO] <= 1'b0;
         if (trig_go)
            ctrl0_ff[ADCSQ_BIT_GO] <= 1'b1;
         if (bus_wr && wb_adr_i == {2'b00, ADCSQ_OFS_CTRL1})
            ctrl1_ff <= {2'b00, wb_dat_i[5:0]};
         if (bus_wr && wb_adr_i == ADCSQ_OFS_CTRL2)
            ctrl2_ff <= {wb_dat_i[7], 1'b0, wb_dat_i[5:0]};
      end
   end

   // result pair and done flag; a full conversion or a bus write updates the result, an abort does not
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         res_hi_ff <= ADCSQ_RST_REG;
         res_lo_ff <= ADCSQ_RST_REG;
         conversion_done_flag_ff <= 1'b0;
      end
      else
      begin
         if (conv_end)
         begin
            if (ctrl2_ff[ADCSQ_BIT_FMT])
               {res_hi_ff, res_lo_ff} <= {4'h0, conv_val};
            else
               {res_hi_ff, res_lo_ff} <= {conv_val, 4'h0};
         end
         else
         begin
            if (bus_wr && wb_adr_i == {2'b00, ADCSQ_OFS_RES_HI})
               res_hi_ff <= wb_dat_i[7:0];
            if (bus_wr && wb_adr_i == {2'b00, ADCSQ_OFS_RES_LO})
               res_lo_ff <= wb_dat_i[7:0];
         end
         if (conv_end)
            conversion_done_flag_ff <= 1'b1;
         else if (bus_wr && wb_adr_i == ADCSQ_OFS_STAT && wb_dat_i[0])
            conversion_done_flag_ff <= 1'b0; // write one to clear; set wins
      end
   end

   // port pin synchroniser; third stage agrees with second before the change counts
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pin_s1_ff <= '0;
         pin_s2_ff <= '0;
         pin_s3_ff <= '0;
         port_ff <= '0;
      end
      else
      begin
         pin_s1_ff <= port_pins;
         pin_s2_ff <= pin_s1_ff;
         pin_s3_ff <= pin_s2_ff;
         for (int i = 0; i < PORT_W; i++)
            if (pin_s2_ff[i] == pin_s3_ff[i])
               port_ff[i] <= pin_s3_ff[i];
      end
   end

   // analog pins: pin_config_select n makes pins below PORT_W-n analog (read as zero)
   logic [PORT_W-1:0] analog_mask;
   always_comb
   begin
      for (int i = 0; i < PORT_W; i++)
         analog_mask[i] = (i < (PORT_W - int'(ctrl1_ff[3:0])));
   end

   // read mux
   always_comb
   begin
      rd_data = 32'h0;
      case (wb_adr_i)
         {2'b00, ADCSQ_OFS_RES_HI}: rd_data[7:0] = res_hi_ff;
         {2'b00, ADCSQ_OFS_RES_LO}: rd_data[7:0] = res_lo_ff;
         {2'b00, ADCSQ_OFS_CTRL0}: rd_data[7:0] = ctrl0_ff;
         {2'b00, ADCSQ_OFS_CTRL1}: rd_data[7:0] = ctrl1_ff;
         ADCSQ_OFS_CTRL2: rd_data[7:0] = ctrl2_ff;
         ADCSQ_OFS_STAT: rd_data[3:0] = {state_ff, conversion_done_flag_ff};
         ADCSQ_OFS_PORT: rd_data[PORT_W-1:0] = port_ff & ~analog_mask;
         default: rd_data = 32'h0;
      endcase
   end

   // single-wait-state slave; unmapped reads give zero
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ack_ff <= 1'b0;
         wb_dat_o <= 32'h0;
      end
      else
      begin
         ack_ff <= wb_cyc_i & wb_stb_i & ~ack_ff;
         wb_dat_o <= rd_data;
      end
   end
   assign wb_ack_o = ack_ff;

   property p_conv_len;
      @(posedge mclk) disable iff (!rst_b)
      $rose(state_ff == ADCSQ_CONV) && tad_len == 7'd2 |-> (state_ff == ADCSQ_CONV || !ctrl0_ff[1]) [*8];
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("conversion too short");
   property p_done;
      @(posedge mclk) disable iff (!rst_b)
      conv_end && !trig_go && !bus_go_set |=> conversion_done_flag_ff && !ctrl0_ff[1] && state_ff == ADCSQ_WAIT;
   endproperty
   a_done: assert property (p_done) else $error("completion effects missing");
   property p_abort;
      @(posedge mclk) disable iff (!rst_b)
      state_ff == ADCSQ_CONV && !ctrl0_ff[1] && !bus_wr |=> $stable({res_hi_ff, res_lo_ff});
   endproperty
   a_abort: assert property (p_abort) else $error("abort changed result");
   property p_delay;
      @(posedge mclk) disable iff (!rst_b)
      state_ff == ADCSQ_IDLE && ctrl0_ff[1] && ctrl0_ff[0] && acq_len == 5'd0 |=> state_ff == ADCSQ_DELAY;
   endproperty
   a_delay: assert property (p_delay) else $error("no start delay");
   property p_trig;
      @(posedge mclk) disable iff (!rst_b)
      trig_go |=> ctrl0_ff[1];
   endproperty
   a_trig: assert property (p_trig) else $error("trigger did not set go");
   property p_ctr;
      @(posedge mclk) disable iff (!rst_b)
      special_trigger && compare_mode_select == ADCSQ_TRIG_MODE |=> counter_reset_ff;
   endproperty
   a_ctr: assert property (p_ctr) else $error("counter not reset");
   property p_dis;
      @(posedge mclk) disable iff (!rst_b)
      !converter_enable && !bus_wr |=> !ctrl0_ff[1];
   endproperty
   a_dis: assert property (p_dis) else $error("trigger acted while disabled");
   property p_wait;
      @(posedge mclk) disable iff (!rst_b)
      $rose(state_ff == ADCSQ_WAIT) |=> holding_discharge_ff;
   endproperty
   a_wait: assert property (p_wait) else $error("no discharge before sample");
endmodule

/* File: verif/adcsq_analog_model.sv */
// analog side model: converted level and digital pin levels
`timescale 1ns/1ns
module adcsq_analog_model
   import adcsq_pkg::*;
#(
   parameter int PORT_W = 12
)
(
   input wire logic mclk,
   input wire logic [31:0] seed,
   output logic [11:0] analog_sample,
   output logic [PORT_W-1:0] port_pins
);
   // level ignores channel and direction, so any pin converts alike
   always_ff @(posedge mclk)
   begin
      analog_sample <= seed[11:0];
      port_pins <= seed[31:32-PORT_W];
   end
endmodule

/* File: verif/adcsq_top_tb_top.sv */
// self-checking bench for the converter sequencer
`timescale 1ns/1ns
module adcsq_top_tb_top
   import adcsq_pkg::*;
;
   localparam logic [5:0] A_HI = {2'b0, ADCSQ_OFS_RES_HI};
   localparam logic [5:0] A_LO = {2'b0, ADCSQ_OFS_RES_LO};
   localparam logic [5:0] A_C0 = {2'b0, ADCSQ_OFS_CTRL0};
   localparam logic [5:0] A_C1 = {2'b0, ADCSQ_OFS_CTRL1};
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic [5:0] adr = 6'h0;
   logic [31:0] dat = 32'h0;
   logic [3:0] sel = 4'h0;
   logic we = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic [3:0] cms = 4'h0;
   logic trig = 1'b0;
   logic [31:0] rnd = 32'hc21c;
   logic [31:0] seed = 32'hc21c;
   logic [31:0] rdat;
   logic ack, crst, dis, samp, done;
   logic [3:0] chs;
   logic [11:0] asmp, pins;
   int miscompares = 0;
   int tests_run = 0;
   logic [31:0] rq[$];
   logic kq[$];
   int cq[$];
   int wq[$];
   int cc = 0;
   int dc = 0;
   logic ps = 1'b0;
   logic pd = 1'b0;
   logic tp = 1'b0;

   adcsq_top u_dut (.mclk(mclk), .rst_b(rst_b), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
      .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
      .compare_mode_select(cms), .special_trigger(trig), .analog_sample(asmp), .port_pins(pins),
      .counter_reset_ff(crst), .holding_discharge_ff(dis), .sampling_ff(samp),
      .conversion_done_flag_ff(done), .channel_sel_ff(chs));
   adcsq_analog_model u_pins (.mclk(mclk), .seed(seed), .analog_sample(asmp), .port_pins(pins));

   initial
   begin
      // one steady clock source, never stopped or switched, so no sleep or idle rules apply
      forever #50 mclk = ~mclk;
   end

   function automatic logic [31:0] xs(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction

   task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_time(input int got, input int exp);
      tests_run++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic finish_test();
      $display("compares %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0 && cq.size() == 0 && wq.size() == 0 && rq.size() == 0 && kq.size() == 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // one classic cycle; request held until ack is sampled
   // no wait limit of its own: a hang is ended by the watchdog
   task automatic wb(input logic [5:0] a, input logic [31:0] d, input logic w, input logic [3:0] s = 4'hf);
      adr <= a;
      dat <= d;
      we <= w;
      sel <= s;
      cyc <= 1'b1;
      stb <= 1'b1;
      @(posedge mclk);
      while (ack !== 1'b1)
         @(posedge mclk);
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic rd(input logic [5:0] a, input logic [31:0] e);
      rq.push_back(e);
      wb(a, 32'h0, 1'b0);
   endtask

   // bounded wait for a discharge pulse and the return to sampling
   task automatic settle();
      int n;
      logic seen;
      n = 0;
      seen = 1'b0;
      while (!(seen && samp === 1'b1) && n < 3000)
      begin
         @(posedge mclk);
         seen = seen | (dis === 1'b1);
         n++;
      end
      if (n == 3000)
         miscompares++;
   endtask

   task automatic pulse(input logic [3:0] m);
      kq.push_back(m == ADCSQ_TRIG_MODE);
      cms <= m;
      trig <= 1'b1;
      @(posedge mclk);
      trig <= 1'b0;
      @(posedge mclk);
   endtask

   // watcher: read data, trigger echo, conversion and discharge lengths
   always @(posedge mclk)
   begin
      if (ack === 1'b1 && we === 1'b0)
         cmp_val(rdat, rq.pop_front());
      if (tp === 1'b1)
         cmp_val({31'h0, crst}, {31'h0, kq.pop_front()});
      tp = trig;
      cc++;
      dc++;
      if (ps === 1'b1 && samp === 1'b0)
         cc = 0;
      if (pd === 1'b0 && dis === 1'b1)
      begin
         if (cq.size() == 0 || cq[0] >= 0)
            cmp_time(cc, cq.size() ? cq[0] : -2);
         if (cq.size())
            void'(cq.pop_front());
         dc = 0;
      end
      if (pd === 1'b1 && dis === 1'b0)
         cmp_time(dc, wq.size() ? wq.pop_front() : -2);
      ps = samp;
      pd = dis;
   end

   initial
   begin
      #2000000;
      miscompares++;
      finish_test();
   end

   initial
   begin
      int t;
      logic [2:0] cs;
      logic [11:0] v;
      logic f;
      repeat (10) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      rd(A_C0, 32'h0);
      rd(ADCSQ_OFS_CTRL2, 32'h0);
      rd(6'h1c, 32'h0);
      wb(ADCSQ_OFS_CTRL2, 32'hff, 1'b1);
      rd(ADCSQ_OFS_CTRL2, 32'hbf);
      wb(ADCSQ_OFS_CTRL2, 32'h00, 1'b1, 4'he);
      rd(ADCSQ_OFS_CTRL2, 32'hbf);
      wb(A_C0, 32'h1, 1'b1);
      // go only after the enable has settled
      repeat (20) @(posedge mclk);
      // every clock select code, alternating justification
      for (int i = 0; i < 8; i++)
      begin
         cs = i[2:0];
         f = i[0];
         t = (cs[1:0] == 2'b11) ? ADCSQ_RC_DIV : 2 << {cs[1:0], cs[2]};
         rnd = xs(rnd);
         seed <= rnd;
         v = rnd[11:0];
         wb(ADCSQ_OFS_CTRL2, {24'h0, f, 1'b0, 3'b010, cs}, 1'b1);
         cq.push_back(ADCSQ_CONV_TAD * t);
         wq.push_back(ADCSQ_WAIT_TAD * t);
         wb(A_C0, {26'h0, i[3:0], 2'b11}, 1'b1);
         settle();
         cmp_val({28'h0, chs}, {28'h0, i[3:0]});
         cmp_val({31'h0, done}, 32'h1);
         rd(A_HI, f ? {28'h0, v[11:8]} : {24'h0, v[11:4]});
         rd(A_LO, f ? {24'h0, v[7:0]} : {24'h0, v[3:0], 4'h0});
         rd(A_C0, {26'h0, i[3:0], 2'b01});
         rd(ADCSQ_OFS_STAT, 32'h1);
         wb(ADCSQ_OFS_STAT, 32'h1, 1'b1);
         cmp_val({31'h0, done}, 32'h0);
         rd(ADCSQ_OFS_STAT, 32'h0);
      end
      // abort mid conversion keeps the written result
      // sixteen-clock bit period: the shortest above the minimum at this clock
      wb(ADCSQ_OFS_CTRL2, 32'h15, 1'b1);
      wb(A_HI, 32'h0a, 1'b1);
      wb(A_LO, 32'h5c, 1'b1);
      cq.push_back(-1);
      wq.push_back(ADCSQ_WAIT_TAD * 16);
      wb(A_C0, 32'h3, 1'b1);
      repeat (150) @(posedge mclk);
      wb(A_C0, 32'h1, 1'b1);
      settle();
      rd(A_HI, 32'h0a);
      rd(A_LO, 32'h5c);
      rd(ADCSQ_OFS_STAT, 32'h0);
      // triggers: wrong mode, disabled, then enabled with no acquisition
      wb(ADCSQ_OFS_CTRL2, 32'h0, 1'b1);
      pulse(4'h3);
      wb(A_C0, 32'h0, 1'b1);
      pulse(ADCSQ_TRIG_MODE);
      repeat (40) @(posedge mclk);
      rd(ADCSQ_OFS_STAT, 32'h0);
      rd(A_C0, 32'h0);
      wb(A_C0, 32'h1, 1'b1);
      repeat (20) @(posedge mclk);
      cq.push_back(ADCSQ_TCY_CLKS + ADCSQ_CONV_TAD * 2);
      wq.push_back(ADCSQ_WAIT_TAD * 2);
      pulse(ADCSQ_TRIG_MODE);
      settle();
      rd(ADCSQ_OFS_STAT, 32'h1);
      rd(A_C0, 32'h1);
      // analog pins read back as zero
      for (int n = 0; n < 13; n += 4)
      begin
         wb(A_C1, n, 1'b1);
         rd(ADCSQ_OFS_PORT, {20'h0, seed[31:20] & ~((12'h1 << (12 - n)) - 12'h1)});
      end
      finish_test();
   end
endmodule
